// [hdec_top.sv]
// Notes on behaviour
// - critical error with cetrig clear raises platform critical-error output, no halt.
// - critical error with cetrig set halts, cause 7, extcause 0.
// - critical-error entry beats every other simultaneous halt reason.
// - resume after critical entry returns to critical state; re-enter or signal.
// - VS-mode breakpoint halts when its control is 1; zero without virtualization.
// - VU-mode breakpoint halts when its control is 1; zero without virtualization.
// - M-mode breakpoint halts when its control is 1; fully writable.
// - S-mode breakpoint halts when its control is 1; zero without S-mode.
// - U-mode breakpoint halts when its control is 1; zero without U-mode.
// - breakpoint with control 0 raises ordinary exception, no halt.
// - stepie clear blocks all interrupts including NMI while stepping.
// - stepie set leaves interrupts enabled while stepping; may be tied 0.
// - stopcount 1 freezes hart counters in debug mode and on halting breakpoint.
// - stopcount 0 lets counters run always.
// - stoptime 1 holds time at entry value; tracks platform timer after exit.
// - stoptime 0 time view always follows platform timer.
// - platform timer may stop only when hart stoptime set and halted.
// - freeze controls may be hardwired; else reset to preset values.
// - extcause 0 means critical error, reported only with cause 7.
// - step set outside debug mode retires one instruction then halts.
// - control fields writable only by debugger; cause fields hardware-updated.
`timescale 1ns/100ps
`default_nettype none
module hdec_top
  import hdec_pkg::*;
#(
  parameter bit HAS_DBLTRP        = 1'b1,
  parameter bit HAS_VIRT          = 1'b1,
  parameter bit HAS_SMODE         = 1'b1,
  parameter bit HAS_UMODE         = 1'b1,
  parameter bit HAS_STEPIE        = 1'b1,
  parameter bit MULTI_HART        = 1'b0,
  parameter bit STOPCOUNT_FIXED   = 1'b0,
  parameter bit STOPCOUNT_PRESET  = 1'b1,
  parameter bit STOPTIME_FIXED    = 1'b0,
  parameter bit STOPTIME_PRESET   = 1'b0
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // core side
  input  wire logic        crit_err_i,
  input  wire hdec_brk_t   brk_i,
  input  wire logic        other_halt_i,
  input  wire logic [2:0]  other_cause_i,
  input  wire logic        step_retire_i,
  input  wire logic        resume_i,
  input  wire logic        instr_retire_i,
  input  wire logic        irq_i,
  input  wire logic        nmi_i,
  input  wire logic [63:0] mtime_i,
  output logic             debug_mode_o,
  output logic             halt_req_o,
  output logic [2:0]       halt_cause_o,
  output logic             brk_exc_o,
  output logic             crit_err_o,
  output logic             irq_o,
  output logic             nmi_o,
  output logic [63:0]      time_o,
  output logic             mtime_stop_ok_o
);

  // ************************************************************
  // controls and hart state
  // ************************************************************
  hdec_ctrl_t  ctrl_q;
  logic        dbg_q;
  logic [2:0]  cause_q;
  logic [2:0]  extcause_q;
  logic [63:0] time_hold_q;
  logic [31:0] instret_q;
  logic [31:0] cycle_q;

  logic        brk_en;
  logic        brk_halt;
  logic        crit_halt;
  logic        step_halt;
  logic        halt;
  logic [2:0]  cause_d;
  logic        wr_fire;
  logic        ar_fire;
  logic [31:0] wr_data;

  // ************************************************************
  // breakpoint decision, combinational at retirement
  // ************************************************************
  always_comb begin
    brk_en = 1'b0;
    if (brk_i.prv == PRV_M) begin
      brk_en = ctrl_q.brk_m;
    end else if (brk_i.prv == PRV_S) begin
      brk_en = brk_i.virt ? ctrl_q.brk_vs : ctrl_q.brk_s;
    end else if (brk_i.prv == PRV_U) begin
      brk_en = brk_i.virt ? ctrl_q.brk_vu : ctrl_q.brk_u;
    end
  end

  assign brk_halt  = brk_i.valid && !dbg_q && brk_en;
  assign brk_exc_o = brk_i.valid && !dbg_q && !brk_en;
  // a resume lands back in the critical state, so crit_err_i re-fires next cycle
  assign crit_halt = crit_err_i && !dbg_q && ctrl_q.cetrig;
  assign crit_err_o = crit_err_i && !dbg_q && !ctrl_q.cetrig;
  assign step_halt = ctrl_q.step && step_retire_i && !dbg_q;
  assign halt      = crit_halt || brk_halt || step_halt || (other_halt_i && !dbg_q);

  // priority: critical, then other causes except step and ebreak, then brk_halt ebreak, then step_halt, then other step or ebreak
  always_comb begin
    cause_d = CAUSE_NONE;
    if (crit_halt) begin
      cause_d = CAUSE_OTHER;
    end else if (other_halt_i && other_cause_i != CAUSE_STEP
                 && other_cause_i != CAUSE_EBREAK) begin
      cause_d = other_cause_i;
    end else if (brk_halt) begin
      cause_d = CAUSE_EBREAK;
    end else if (step_halt || other_halt_i) begin
      cause_d = (other_halt_i && !step_halt) ? other_cause_i : CAUSE_STEP;
    end
  end

  assign halt_req_o   = halt;
  assign halt_cause_o = cause_d;
  assign debug_mode_o = dbg_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dbg_q <= 1'b0;
    end else if (halt) begin
      dbg_q <= 1'b1;
    end else if (resume_i && dbg_q) begin
      dbg_q <= 1'b0;
    end
  end

  // cause is captured only on entry and stays readable until the next halt
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cause_q    <= CAUSE_NONE;
      extcause_q <= EXT_CRIT_ERR;
    end else if (halt) begin
      cause_q    <= cause_d;
      extcause_q <= EXT_CRIT_ERR;
    end
  end

  // ************************************************************
  // interrupt gating while stepping
  // ************************************************************
  logic step_gate;
  assign step_gate = ctrl_q.step && !dbg_q && !ctrl_q.stepie;
  assign irq_o     = irq_i && !step_gate;
  assign nmi_o     = nmi_i && !step_gate;

  // ************************************************************
  // counters and time view
  // ************************************************************
  logic cnt_frozen;
  assign cnt_frozen = ctrl_q.stopcount && (dbg_q || brk_halt);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      instret_q <= 32'h0000_0000;
    end else if (instr_retire_i && !cnt_frozen) begin
      instret_q <= instret_q + 32'h0000_0001;
    end
  end

  // a cycle count shared by several harts must not stall for one of them
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cycle_q <= 32'h0000_0000;
    end else if (MULTI_HART || !cnt_frozen) begin
      cycle_q <= cycle_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      time_hold_q <= 64'h0000_0000_0000_0000;
    end else if (!dbg_q) begin
      time_hold_q <= mtime_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      time_o <= 64'h0000_0000_0000_0000;
    end else begin
      time_o <= (dbg_q && ctrl_q.stoptime) ? time_hold_q : mtime_i;
    end
  end

  assign mtime_stop_ok_o = dbg_q && ctrl_q.stoptime;

  // ************************************************************
  // axi4-lite slave, one write and one read at a time
  // ************************************************************
  logic       aw_held_q;
  logic       w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic       wr_hit;

  // bvalid rises on the edge after both halves are held
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_fire       = aw_held_q && w_held_q;
  assign wr_hit        = (awaddr_q == DCS_OFFSET);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // an unstrobed lane writes zeros, so controls in that byte clear
  localparam int LANES  = 4;
  localparam int LANE_W = 8;

  always_comb begin
    for (int b = 0; b < LANES; b++) begin
      wr_data[b*LANE_W +: LANE_W] = wstrb_q[b] ? wdata_q[b*LANE_W +: LANE_W] : '0;
    end
  end

  // only the debugger's bus port writes controls; cause is hardware-owned
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q.cetrig    <= 1'b0;
      ctrl_q.brk_vs    <= 1'b0;
      ctrl_q.brk_vu    <= 1'b0;
      ctrl_q.brk_m     <= 1'b0;
      ctrl_q.brk_s     <= 1'b0;
      ctrl_q.brk_u     <= 1'b0;
      ctrl_q.stepie    <= 1'b0;
      ctrl_q.stopcount <= STOPCOUNT_PRESET;
      ctrl_q.stoptime  <= STOPTIME_PRESET;
      ctrl_q.step      <= 1'b0;
    end else if (wr_fire && wr_hit) begin
      ctrl_q.cetrig <= HAS_DBLTRP && wr_data[FLD_CETRIG];
      ctrl_q.brk_vs <= HAS_VIRT && wr_data[FLD_BRK_VS];
      ctrl_q.brk_vu <= HAS_VIRT && wr_data[FLD_BRK_VU];
      ctrl_q.brk_m  <= wr_data[FLD_BRK_M];
      ctrl_q.brk_s  <= HAS_SMODE && wr_data[FLD_BRK_S];
      ctrl_q.brk_u  <= HAS_UMODE && wr_data[FLD_BRK_U];
      // stepie writes while running are dropped; the debugger must halt first
      if (dbg_q) begin
        ctrl_q.stepie <= HAS_STEPIE && wr_data[FLD_STEPIE];
        ctrl_q.step   <= wr_data[FLD_STEP];
      end
      ctrl_q.stopcount <= STOPCOUNT_FIXED ? STOPCOUNT_PRESET
                                          : wr_data[FLD_STOPCOUNT];
      ctrl_q.stoptime  <= STOPTIME_FIXED ? STOPTIME_PRESET
                                         : wr_data[FLD_STOPTIME];
    end
  end

  logic        r_busy_q;
  logic [7:0]  araddr_q;
  logic [31:0] dcs_word;
  logic [31:0] stat_word;

  always_comb begin
    dcs_word = 32'h0000_0000;
    dcs_word[FLD_EXT_LO +: 3]   = (cause_q == CAUSE_OTHER) ? extcause_q : 3'h0;
    dcs_word[FLD_CETRIG]        = ctrl_q.cetrig;
    dcs_word[FLD_BRK_VS]        = ctrl_q.brk_vs;
    dcs_word[FLD_BRK_VU]        = ctrl_q.brk_vu;
    dcs_word[FLD_BRK_M]         = ctrl_q.brk_m;
    dcs_word[FLD_BRK_S]         = ctrl_q.brk_s;
    dcs_word[FLD_BRK_U]         = ctrl_q.brk_u;
    dcs_word[FLD_STEPIE]        = ctrl_q.stepie;
    dcs_word[FLD_STOPCOUNT]     = ctrl_q.stopcount;
    dcs_word[FLD_STOPTIME]      = ctrl_q.stoptime;
    dcs_word[FLD_CAUSE_LO +: 3] = cause_q;
    dcs_word[FLD_STEP]          = ctrl_q.step;
  end

  assign stat_word     = {28'h0000000, crit_err_o, mtime_stop_ok_o, step_gate, dbg_q};
  assign s_axi_arready = !r_busy_q;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_busy_q     <= 1'b0;
      araddr_q     <= 8'h00;
      s_axi_rvalid <= 1'b0;
    end else if (ar_fire) begin
      r_busy_q     <= 1'b1;
      araddr_q     <= s_axi_araddr;
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      r_busy_q     <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        DCS_OFFSET:  s_axi_rdata <= dcs_word;
        STAT_OFFSET: s_axi_rdata <= stat_word;
        TIME_LO_OFS: s_axi_rdata <= time_o[31:0];
        TIME_HI_OFS: s_axi_rdata <= time_o[63:32];
        INSTRET_OFS: s_axi_rdata <= instret_q;
        CYCLE_OFS:   s_axi_rdata <= cycle_q;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
  end

endmodule // hdec_top
`default_nettype wire

// [hdec_pkg.sv]
package hdec_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] DCS_OFFSET    = 8'h00;
  localparam logic [7:0] STAT_OFFSET   = 8'h04;
  localparam logic [7:0] TIME_LO_OFS   = 8'h08;
  localparam logic [7:0] TIME_HI_OFS   = 8'h0C;
  localparam logic [7:0] INSTRET_OFS   = 8'h10;
  localparam logic [7:0] CYCLE_OFS     = 8'h14;

  // ************************************************************
  // control word field positions
  // ************************************************************
  localparam int FLD_CETRIG    = 19;
  localparam int FLD_BRK_VS    = 17;
  localparam int FLD_BRK_VU    = 16;
  localparam int FLD_BRK_M     = 15;
  localparam int FLD_BRK_S     = 13;
  localparam int FLD_BRK_U     = 12;
  localparam int FLD_STEPIE    = 11;
  localparam int FLD_STOPCOUNT = 10;
  localparam int FLD_STOPTIME  = 9;
  localparam int FLD_CAUSE_LO  = 6;
  localparam int FLD_EXT_LO    = 24;
  localparam int FLD_STEP      = 2;

  // ************************************************************
  // halt causes and privilege codes
  // ************************************************************
  localparam logic [2:0] CAUSE_NONE    = 3'h0;
  localparam logic [2:0] CAUSE_EBREAK  = 3'h1;
  localparam logic [2:0] CAUSE_TRIGGER = 3'h2;
  localparam logic [2:0] CAUSE_HALTREQ = 3'h3;
  localparam logic [2:0] CAUSE_STEP    = 3'h4;
  localparam logic [2:0] CAUSE_RSTHALT = 3'h5;
  localparam logic [2:0] CAUSE_GROUP   = 3'h6;
  localparam logic [2:0] CAUSE_OTHER   = 3'h7;
  localparam logic [2:0] EXT_CRIT_ERR  = 3'h0;

  localparam logic [1:0] PRV_U = 2'h0;
  localparam logic [1:0] PRV_S = 2'h1;
  localparam logic [1:0] PRV_M = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       valid;
    logic [1:0] prv;
    logic       virt;
  } hdec_brk_t;

  typedef struct packed {
    logic cetrig;
    logic brk_vs;
    logic brk_vu;
    logic brk_m;
    logic brk_s;
    logic brk_u;
    logic stepie;
    logic stopcount;
    logic stoptime;
    logic step;
  } hdec_ctrl_t;

endpackage

// [hdec_dbg.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// debugger side: axi4-lite master
// ****************************************
module hdec_dbg (
  input  wire logic        clock_i,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
  end
  // called just after a rising edge; handshakes are judged at the falling edge,
  // where inputs are settled, and acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clock_i);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      @(posedge clock_i);
      // released lines show the inverse so stale values never look valid
      if (ah) s_axi_awvalid <= 1'b0;
      if (ah) s_axi_awaddr <= ~a;
      if (wh) s_axi_wvalid <= 1'b0;
      if (wh) s_axi_wdata <= ~d;
    end
    // bready stays high between writes so no step drives it twice
  endtask
  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clock_i);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      @(posedge clock_i);
      if (ah) s_axi_arvalid <= 1'b0;
      if (ah) s_axi_araddr <= ~a;
    end
  endtask
endmodule // hdec_dbg
`default_nettype wire

// [hdec_chk_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module hdec_chk
  import hdec_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        crit_err_i,
  input wire hdec_brk_t   brk_i,
  input wire logic        other_halt_i,
  input wire logic        irq_i,
  input wire logic        nmi_i,
  input wire logic [63:0] mtime_i,
  input wire logic        debug_mode_o,
  input wire logic        halt_req_o,
  input wire logic [2:0]  halt_cause_o,
  input wire logic        brk_exc_o,
  input wire logic        crit_err_o,
  input wire logic        irq_o,
  input wire logic        nmi_o,
  input wire logic [63:0] time_o,
  input wire logic        mtime_stop_ok_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_crit_path;
    crit_err_i && !debug_mode_o |-> crit_err_o != halt_req_o;
  endproperty
  a_crit_path: assert property (p_crit_path) else $error("crit path");
  property p_crit_cause;
    halt_req_o && crit_err_i && !crit_err_o |-> halt_cause_o == CAUSE_OTHER;
  endproperty
  a_crit_cause: assert property (p_crit_cause) else $error("crit cause");
  property p_entry;
    halt_req_o |=> debug_mode_o;
  endproperty
  a_entry: assert property (p_entry) else $error("no entry");
  property p_brk_split;
    brk_i.valid && !debug_mode_o |-> halt_req_o || brk_exc_o;
  endproperty
  a_brk_split: assert property (p_brk_split) else $error("brk lost");
  property p_brk_exc;
    brk_exc_o |-> brk_i.valid && !halt_req_o;
  endproperty
  a_brk_exc: assert property (p_brk_exc) else $error("brk exc");
  property p_brk_cause;
    brk_i.valid && halt_req_o && !crit_err_i && !other_halt_i |-> halt_cause_o == CAUSE_EBREAK;
  endproperty
  a_brk_cause: assert property (p_brk_cause) else $error("brk cause");
  property p_stop_ok;
    mtime_stop_ok_o |-> debug_mode_o;
  endproperty
  a_stop_ok: assert property (p_stop_ok) else $error("timer stop");
  // the halt cycle is left out: the entry value may be taken there or one edge before
  property p_time;
    !$past(debug_mode_o) && !$past(halt_req_o) && $past(rst_n_i) |-> time_o == $past(mtime_i);
  endproperty
  a_time: assert property (p_time) else $error("time view");
  property p_wr;
    s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("no bvalid");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("no rvalid");
  property p_irq;
    irq_o || nmi_o |-> (irq_o <= irq_i) && (nmi_o <= nmi_i);
  endproperty
  a_irq: assert property (p_irq) else $error("irq invented");
endmodule // hdec_chk
bind hdec_top hdec_chk u_chk (.*);
`default_nettype wire

// [tb_hart_debug_entry_control.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("Error %0t: got %h exp %h", $time, g, e); \
  end \
end
module tb_hart_debug_entry_control;
  import hdec_pkg::*;
  localparam logic [31:0] SC = 32'h1 << FLD_STOPCOUNT;
  localparam logic [31:0] ST = 32'h1 << FLD_STOPTIME;
  localparam logic [31:0] BM = 32'h1 << FLD_BRK_M;
  localparam logic [31:0] SP = 32'h1 << FLD_STEP;
  localparam logic [31:0] IE = 32'h1 << FLD_STEPIE;
  localparam logic [31:0] CE = 32'h1 << FLD_CETRIG;
  logic clock_i = 1'b0, rst_n_i = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, ctrl;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic crit_err_i = 1'b0, other_halt_i = 1'b0, step_retire_i = 1'b0, resume_i = 1'b0;
  logic instr_retire_i = 1'b0, irq_i = 1'b0, nmi_i = 1'b0, hit;
  hdec_brk_t brk_i = '0;
  logic [2:0] other_cause_i = '0, halt_cause_o;
  logic [63:0] mtime_i = '0, time_o, ta, tv;
  logic debug_mode_o, halt_req_o, brk_exc_o, crit_err_o, irq_o, nmi_o, mtime_stop_ok_o;
  int fails = 0, total_checks = 0, cyc = 0, b, m;
  integer seed = 32'h50d71ced;
  logic [33:0] rq[$], rx;
  logic [1:0] bq[$], bx;
  // mode table: U, S, M, VS, VU
  logic [1:0] mprv [5] = '{PRV_U, PRV_S, PRV_M, PRV_S, PRV_U};
  logic       mv   [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  int         mbit [5] = '{FLD_BRK_U, FLD_BRK_S, FLD_BRK_M, FLD_BRK_VS, FLD_BRK_VU};
  hdec_top u_dut (.*);
  hdec_dbg u_dbg (.*);
  initial forever #4 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ****************************************
  // response watcher
  // ****************************************
  always @(negedge clock_i) begin
    if (s_axi_rvalid && s_axi_rready) begin
      rx = rq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, rx)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bx = bq.pop_front();
      `CHK(s_axi_bresp, bx)
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, d});
    u_dbg.rd(a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    bq.push_back(r);
    u_dbg.wr(a, d);
  endtask
  task automatic brk(input int k, input logic h);
    brk_i <= {1'b1, mprv[k], mv[k]};
    @(negedge clock_i);
    `CHK(halt_req_o, h)
    `CHK(brk_exc_o, !h)
    if (h) `CHK(halt_cause_o, CAUSE_EBREAK)
    @(posedge clock_i);
    brk_i <= '0;
    @(posedge clock_i);
  endtask
  task automatic resume();
    resume_i <= 1'b1;
    @(posedge clock_i);
    resume_i <= 1'b0;
    tick(2);
  endtask
  task automatic retire(input int n);
    repeat (n) begin
      instr_retire_i <= 1'b1;
      @(posedge clock_i);
    end
    instr_retire_i <= 1'b0;
  endtask
  task automatic stepped(input logic g);
    @(negedge clock_i);
    `CHK({irq_o, nmi_o}, {g, g})
    @(posedge clock_i);
    step_retire_i <= 1'b1;
    @(negedge clock_i);
    `CHK({halt_req_o, halt_cause_o}, {1'b1, CAUSE_STEP})
    @(posedge clock_i);
    step_retire_i <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    tick(12);
    rst_n_i <= 1'b1;
    tick(1);
    rd(DCS_OFFSET, SC);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'hFFFFFFFF, RESP_SLVERR);
    retire(3);
    rd(INSTRET_OFS, 32'h3);
    for (b = 0; b < 5; b++) begin
      wr(DCS_OFFSET, (32'h1 << mbit[b]) | SC);
      for (m = 0; m < 5; m++) begin
        brk(m, b == m);
        if (b == m) resume();
      end
    end
    ta = {$random(seed), $random(seed)};
    tv = {$random(seed), $random(seed)};
    mtime_i <= ta;
    wr(DCS_OFFSET, BM | SC | ST);
    brk(2, 1'b1);
    mtime_i <= tv;
    rd(DCS_OFFSET, BM | SC | ST | (32'h1 << FLD_CAUSE_LO));
    retire(3);
    rd(INSTRET_OFS, 32'h3);
    rd(TIME_LO_OFS, ta[31:0]);
    @(negedge clock_i);
    `CHK(mtime_stop_ok_o, 1'b1)
    @(posedge clock_i);
    resume();
    rd(TIME_LO_OFS, tv[31:0]);
    wr(DCS_OFFSET, BM);
    brk(2, 1'b1);
    mtime_i <= ta ^ tv;
    tick(3);
    rd(TIME_LO_OFS, ta[31:0] ^ tv[31:0]);
    retire(2);
    rd(INSTRET_OFS, 32'h5);
    @(negedge clock_i);
    `CHK(mtime_stop_ok_o, 1'b0)
    @(posedge clock_i);
    wr(DCS_OFFSET, SP);
    rd(DCS_OFFSET, SP | (32'h1 << FLD_CAUSE_LO));
    resume();
    irq_i <= 1'b1;
    nmi_i <= 1'b1;
    stepped(1'b0);
    wr(DCS_OFFSET, SP | IE);
    resume();
    stepped(1'b1);
    irq_i <= 1'b0;
    nmi_i <= 1'b0;
    wr(DCS_OFFSET, 32'h0);
    resume();
    // step written while running must not take hold
    wr(DCS_OFFSET, SP);
    rd(DCS_OFFSET, 32'(CAUSE_STEP) << FLD_CAUSE_LO);
    crit_err_i <= 1'b1;
    @(negedge clock_i);
    `CHK({crit_err_o, halt_req_o}, 2'b10)
    @(posedge clock_i);
    crit_err_i <= 1'b0;
    wr(DCS_OFFSET, CE | BM);
    crit_err_i <= 1'b1;
    brk_i <= {1'b1, PRV_M, 1'b0};
    other_halt_i <= 1'b1;
    other_cause_i <= CAUSE_HALTREQ;
    @(negedge clock_i);
    `CHK({halt_req_o, halt_cause_o}, {1'b1, CAUSE_OTHER})
    @(posedge clock_i);
    brk_i <= '0;
    other_halt_i <= 1'b0;
    ctrl = (32'(CAUSE_OTHER) << FLD_CAUSE_LO) | (32'(EXT_CRIT_ERR) << FLD_EXT_LO);
    rd(DCS_OFFSET, CE | BM | ctrl);
    resume_i <= 1'b1;
    @(posedge clock_i);
    resume_i <= 1'b0;
    hit = 1'b0;
    repeat (4) begin
      @(negedge clock_i);
      hit = hit | halt_req_o;
    end
    `CHK(hit, 1'b1)
    @(posedge clock_i);
    wr(DCS_OFFSET, 32'h0);
    resume();
    @(negedge clock_i);
    `CHK({crit_err_o, debug_mode_o}, 2'b10)
    @(posedge clock_i);
    crit_err_i <= 1'b0;
    tick(2);
    tally_and_finish();
  end
endmodule // tb_hart_debug_entry_control
`default_nettype wire
